// file: asrc_pkg.sv
// Package: pin map, request carrier and timing counts for the split-I/O SRAM host controller
package asrc_pkg;
    localparam int ASRC_ADDR_W = 14;
    localparam int ASRC_DATA_W = 4;
    localparam int ASRC_DEPTH = 16384;
    localparam int ASRC_CLK_NS = 10;
    // Slowest grade figures, ns
    localparam int ASRC_ADDR_ACCESS_NS = 85;
    localparam int ASRC_GATE_ACCESS_NS = 35;
    localparam int ASRC_DESELECT_FLOAT_NS = 30;
    localparam int ASRC_STROBE_PULSE_NS = 45;
    localparam int ASRC_SELECT_PULSE_NS = 65;
    localparam int ASRC_DATA_SETUP_NS = 35;
    localparam int ASRC_ADDR_SETUP_END_NS = 65;
    localparam int ASRC_ADDR_HOLD_NS = 0;
    // Least times round up, at least one cycle
    localparam int ASRC_READ_CYC = (ASRC_ADDR_ACCESS_NS + ASRC_CLK_NS - 1) / ASRC_CLK_NS + 1;
    localparam int ASRC_FLOAT_CYC = (ASRC_DESELECT_FLOAT_NS + ASRC_CLK_NS - 1) / ASRC_CLK_NS;
    localparam int ASRC_SEL_CYC = (ASRC_SELECT_PULSE_NS + ASRC_CLK_NS - 1) / ASRC_CLK_NS;
    localparam int ASRC_STB_CYC = (ASRC_STROBE_PULSE_NS + ASRC_CLK_NS - 1) / ASRC_CLK_NS;
    localparam int ASRC_CNT_W = 5;
    localparam logic [ASRC_CNT_W-1:0] ASRC_CNT_ZERO = 5'h00;

    typedef struct packed {
        logic write;
        logic [ASRC_ADDR_W-1:0] addr;
        logic [ASRC_DATA_W-1:0] wdata;
    } asrc_req_t;

    typedef struct packed {
        logic chip_select_a_n;
        logic chip_select_b_n;
        logic write_strobe_n;
        logic output_gate_n;
        logic [ASRC_ADDR_W-1:0] addr;
        logic [ASRC_DATA_W-1:0] data_in;
    } asrc_pins_t;

    typedef enum logic [4:0] {
        ASRC_IDLE = 5'h01,
        ASRC_SETUP = 5'h02,
        ASRC_READ = 5'h04,
        ASRC_WRITE = 5'h08,
        ASRC_RECOVER = 5'h10
    } asrc_state_t;

    function automatic logic [ASRC_CNT_W-1:0] asrc_cyc(input int n);
        return ASRC_CNT_W'(n - 1);
    endfunction : asrc_cyc
endpackage : asrc_pkg

// file: asrc_timer.sv
// Down counter that times the held read or write phase and the recovery phase of a memory cycle
`timescale 1ns/1ps
module asrc_timer
    import asrc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [ASRC_CNT_W-1:0] load_val,
    output logic done
);
    logic [ASRC_CNT_W-1:0] cnt_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= ASRC_CNT_ZERO;
        end else if (load) begin
            cnt_q <= load_val;
        end else if (cnt_q != ASRC_CNT_ZERO) begin
            cnt_q <= cnt_q - 5'h01;
        end
    end

    // Not gated by load: the controller reloads on done, which would close a loop
    assign done = (cnt_q == ASRC_CNT_ZERO);
endmodule : asrc_timer

// file: asrc_ctrl.sv
// Host controller driving a 16K x 4 asynchronous SRAM with split data pins
// What this block does
// - Host drives fourteen address lines selecting one word.
// - Read: address first, then both selects low, strobe high, wait access time.
// - Any select or strobe rising ends a write; host chooses strobe.
// - Host holds strobe and selects low together for 70 ns, covering 45 ns and 65 ns.
// - Host makes data valid 35 ns before write end, holds after.
// - Host sets address before write start, 65 ns before end, holds it.
// - Host keeps select or strobe high while address changes.
`timescale 1ns/1ps
module asrc_ctrl
    import asrc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire asrc_req_t req,
    output logic req_ready,
    output logic [ASRC_DATA_W-1:0] rd_data,
    output logic rd_valid,
    output logic wr_done,
    output asrc_pins_t pins,
    input wire logic [ASRC_DATA_W-1:0] data_out,
    input wire logic data_out_en
);
    asrc_state_t state_q;
    asrc_req_t req_q;
    asrc_pins_t pins_q;
    logic [ASRC_DATA_W-1:0] rd_data_q;
    logic rd_valid_q;
    logic wr_done_q;
    logic tmr_load;
    logic [ASRC_CNT_W-1:0] tmr_val;
    logic tmr_done;

    asrc_timer u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    assign req_ready = (state_q == ASRC_IDLE);
    assign pins = pins_q;
    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;
    assign wr_done = wr_done_q;

    always_comb begin
        tmr_load = 1'b0;
        tmr_val = ASRC_CNT_ZERO;
        unique case (state_q)
            ASRC_IDLE: begin
                tmr_load = req_valid;
                tmr_val = ASRC_CNT_ZERO;
            end
            ASRC_SETUP: begin
                tmr_load = 1'b1;
                // Select pulse covers the strobe pulse, data setup and address setup
                tmr_val = req_q.write ? asrc_cyc(ASRC_SEL_CYC)
                                      : asrc_cyc(ASRC_READ_CYC);
            end
            ASRC_READ, ASRC_WRITE: begin
                tmr_load = tmr_done;
                tmr_val = asrc_cyc(ASRC_FLOAT_CYC);
            end
            ASRC_RECOVER: begin
                tmr_load = 1'b0;
                tmr_val = ASRC_CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ASRC_IDLE;
        end else begin
            unique case (state_q)
                ASRC_IDLE: if (req_valid) state_q <= ASRC_SETUP;
                ASRC_SETUP: state_q <= req_q.write ? ASRC_WRITE : ASRC_READ;
                ASRC_READ, ASRC_WRITE: if (tmr_done) state_q <= ASRC_RECOVER;
                ASRC_RECOVER: if (tmr_done) state_q <= ASRC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_q <= '0;
        end else if (state_q == ASRC_IDLE && req_valid) begin
            req_q <= req;
        end
    end

    // Pins: address and data settle a cycle before any select or strobe falls
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pins_q <= '{chip_select_a_n: 1'b1, chip_select_b_n: 1'b1, write_strobe_n: 1'b1,
                        output_gate_n: 1'b1, addr: '0, data_in: '0};
        end else begin
            unique case (state_q)
                ASRC_IDLE: begin
                    if (req_valid) begin
                        pins_q.addr <= req.addr;
                        pins_q.data_in <= req.wdata;
                    end
                end
                ASRC_SETUP: begin
                    pins_q.chip_select_a_n <= 1'b0;
                    pins_q.chip_select_b_n <= 1'b0;
                    pins_q.write_strobe_n <= ~req_q.write;
                    pins_q.output_gate_n <= req_q.write;
                end
                ASRC_READ, ASRC_WRITE: begin
                    if (tmr_done) begin
                        // Strobe ends the write; selects rise with it, and data stays on the pins until the next request is taken
                        pins_q.write_strobe_n <= 1'b1;
                        pins_q.chip_select_a_n <= 1'b1;
                        pins_q.chip_select_b_n <= 1'b1;
                        pins_q.output_gate_n <= 1'b1;
                    end
                end
                ASRC_RECOVER: begin
                    pins_q.output_gate_n <= 1'b1;
                end
            endcase
        end
    end

    // Sample only at the end of the full access time, past any hold window
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data_q <= '0;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= 1'b0;
            if (state_q == ASRC_READ && tmr_done && data_out_en) begin
                rd_data_q <= data_out;
                rd_valid_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_done_q <= 1'b0;
        end else begin
            wr_done_q <= (state_q == ASRC_WRITE) && tmr_done;
        end
    end
endmodule : asrc_ctrl

// file: asrc_properties.sv
// Checker for the SRAM host controller pin sequencing and answer timing
`timescale 1ns/1ps
module asrc_checker
    import asrc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire asrc_req_t req,
    input wire logic req_ready,
    input wire logic [ASRC_DATA_W-1:0] rd_data,
    input wire logic rd_valid,
    input wire logic wr_done,
    input wire asrc_pins_t pins,
    input wire logic [ASRC_DATA_W-1:0] data_out,
    input wire logic data_out_en
);
    wire logic rd = req_valid && req_ready && !req.write;
    wire logic wr = req_valid && req_ready && req.write;
    wire logic cs = !pins.chip_select_a_n && !pins.chip_select_b_n;
    wire logic stb = !pins.write_strobe_n;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    rd_pins_a: assert property (rd |-> ##2 cs && !pins.output_gate_n && !stb)
        else $error("read pins wrong");
    rd_time_a: assert property (rd |-> ##12 rd_valid) else $error("read late");
    wr_time_a: assert property (wr |-> ##9 wr_done) else $error("write late");
    wr_enter_a: assert property ($rose(stb) |-> $rose(cs) && pins.output_gate_n)
        else $error("strobe without selects");
    wr_pulse_a: assert property ($rose(stb) |-> stb[*7] ##1 !stb && !cs)
        else $error("strobe pulse wrong");
    addr_hold_a: assert property (cs && $past(cs) |-> $stable(pins.addr))
        else $error("address moved");
    data_hold_a: assert property (stb && $past(stb) |-> $stable(pins.data_in))
        else $error("write data moved");
    rd_word_a: assert property (rd_valid |-> rd_data == $past(data_out))
        else $error("read word differs");
endmodule : asrc_checker
bind asrc_ctrl asrc_checker i_asrc_checker (.clk, .rst_n, .req_valid, .req, .req_ready,
    .rd_data, .rd_valid, .wr_done, .pins, .data_out, .data_out_en);

// file: asrc_sram_model.sv
// Behavioural split-pin static memory, floating-output write variant
`timescale 1ns/1ps
module asrc_sram_model
    import asrc_pkg::*;
#(
    parameter int ACC_CYC = 9,
    parameter int PD_CYC = 9,
    parameter bit ECHO_WR = 1'b0
)
(
    input wire logic clk,
    input wire asrc_pins_t pins,
    output logic [ASRC_DATA_W-1:0] data_out,
    output logic data_out_en
);
    logic [ASRC_DATA_W-1:0] mem [ASRC_DEPTH];
    logic [ASRC_DATA_W-1:0] last_q = 4'h0;
    logic [ASRC_DATA_W-1:0] din_q = 4'h0;
    logic [ASRC_ADDR_W-1:0] addr_q = 14'h0000;
    logic sel_q = 1'b0;
    logic stb_q = 1'b0;
    logic low_power_state;
    int age_q = 0;
    int pwr_q = 0;
    wire logic sel = !pins.chip_select_a_n && !pins.chip_select_b_n;
    wire logic stb = !pins.write_strobe_n;
    // Wake on select fall, strobe fall or address move while selected, data move in a write
    wire logic wake = (sel && !sel_q) || (sel && stb && !stb_q) || (sel && pins.addr != addr_q)
        || (sel && stb && pins.data_in != din_q);
    always @(posedge clk) begin
        if (sel && stb)
            mem[pins.addr] <= pins.data_in;
        // Address move restarts the access; old data is never relied on
        age_q <= (sel && !stb && pins.addr == addr_q) ? age_q + 1 : 0;
        pwr_q <= wake ? PD_CYC : (pwr_q > 0 ? pwr_q - 1 : 0);
        last_q <= data_out;
        addr_q <= pins.addr;
        din_q <= pins.data_in;
        sel_q <= sel;
        stb_q <= stb;
    end
    assign low_power_state = (pwr_q == 0);
    // Floating write variant unless the echo is asked for
    assign data_out_en = sel && !pins.output_gate_n
        && (!stb || ECHO_WR);
    // Early or floating: churn, so stale data never matches by luck
    always_comb begin
        data_out = ~last_q;
        if (data_out_en && stb)
            data_out = pins.data_in;
        else if (data_out_en && age_q >= ACC_CYC - 1)
            data_out = mem[pins.addr];
    end
endmodule : asrc_sram_model

// file: asrc_tb.sv
// Bench: controller against the memory model
`timescale 1ns/1ps
module testbench;
    import asrc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0;
    asrc_req_t req = '0;
    logic req_ready, rd_valid, wr_done, data_out_en;
    logic [ASRC_DATA_W-1:0] rd_data, data_out, q;
    asrc_pins_t pins;
    int miscompares = 0;
    int check_count = 0;
    asrc_ctrl i_asrc_ctrl (.clk, .rst_n, .req_valid, .req, .req_ready, .rd_data,
        .rd_valid, .wr_done, .pins, .data_out, .data_out_en);
    asrc_sram_model i_asrc_sram_model (.clk, .pins, .data_out, .data_out_en);
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic complete_run();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Valid stays up while busy, so a refused request is held and not lost
    task automatic xfer(input logic w, input logic [13:0] a, input logic [3:0] d);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{w, a, d};
        @(negedge clk);
        for (n = 0; n < 50 && !req_ready; n++)
            @(negedge clk);
        if (n == 50) begin
            miscompares++;
            $display("ERROR %0t request never taken", $time);
            complete_run();
        end
        @(posedge clk);
        req_valid <= 1'b0;
        @(negedge clk);
        for (n = 0; n < 50 && !rd_valid && !wr_done; n++)
            @(negedge clk);
        // Negedges from the take to the pulse: one setup cycle, then the held phase
        chk(8'(n), w ? 8'(ASRC_SEL_CYC + 1) : 8'(ASRC_READ_CYC + 1));
        if (n == 50)
            complete_run();
        q = rd_data;
    endtask : xfer
    // Walking address bits and the top word catch any aliased decode line
    task automatic t_decode();
        for (int k = 0; k < 15; k++)
            xfer(1'b1, k < 14 ? 14'h0001 << k : 14'h3fff, 4'(k + 1));
        xfer(1'b1, 14'h0001, 4'h0);
        for (int k = 0; k < 15; k++) begin
            xfer(1'b0, k < 14 ? 14'h0001 << k : 14'h3fff, 4'h0);
            chk({4'h0, q}, k == 0 ? 8'h00 : 8'(k + 1));
        end
    endtask : t_decode
    // Quiet bus after traffic: the memory must have dropped to low power
    task automatic t_power();
        repeat (ASRC_READ_CYC) @(negedge clk);
        chk({7'h00, i_asrc_sram_model.low_power_state}, 8'h01);
    endtask : t_power
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_decode();
        t_power();
        complete_run();
    end
endmodule : testbench
